//--- inc/shp_pkg.sv
// shared constants, state codes and command decoding for the serial host command port
// assumes a 100 MHz system clock and a host that frames every transaction with its select line
`default_nettype none

package shp_pkg;

  // ==========================================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;                          // sys_clk period
  localparam int POLL_TIME_NS  = 250000;                      // write poll period
  localparam int POLL_CYCLES   = POLL_TIME_NS / CLK_PERIOD_NS; // longest time, rounded down

  // ==========================================================================
  // command byte fields
  localparam int CMD_DATA_BIT = 7;                            // set: data bytes follow
  localparam int CMD_READ_BIT = 6;                            // set: device replies
  localparam int CMD_TWO_BIT  = 5;                            // set: two data bytes

  // ==========================================================================
  // addresses handled inside the block
  localparam logic [7:0] ADDR_MODE   = 8'h81;                 // rx/tx mode, one byte
  localparam logic [7:0] ADDR_MASK   = 8'h82;                 // interrupt mask, one byte
  localparam logic [7:0] ADDR_DIV0   = 8'ha4;                 // first of four divider entries
  localparam logic [7:0] ADDR_STATUS = 8'hc6;                 // status, one byte read

  // ==========================================================================
  // fields and reset values
  localparam int         MODE_RX_BIT  = 0;
  localparam int         MODE_TX_BIT  = 1;
  localparam logic [7:0] MODE_RESET   = 8'h00;                // idle after reset
  localparam logic [7:0] MASK_RESET   = 8'h00;                // every event masked
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam int         DIV_W        = 12;
  localparam int         NUM_DIV      = 4;
  // defaults suit a 6.144 MHz reference
  localparam logic [11:0] DIV_DEFAULT [0:3] = '{12'h020, 12'h200, 12'h140, 12'h008};

  // ==========================================================================
  // transaction states
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,                                       // deselected
    ST_ADDR  = 4'b0010,                                       // shifting address byte
    ST_WDATA = 4'b0100,                                       // shifting write data
    ST_RDATA = 4'b1000                                        // replying
  } shp_state_t;
  // a zero-length frame rests in ST_ADDR and a completed write in ST_WDATA, both with done flag, see module

  // number of data bytes the address byte announces
  function automatic logic [1:0] shp_cmd_len(input logic [7:0] a);
    if (!a[CMD_DATA_BIT]) begin
      return 2'h0;
    end
    return a[CMD_TWO_BIT] ? 2'h2 : 2'h1;
  endfunction

  // does the address byte ask for a reply
  function automatic logic shp_cmd_rd(input logic [7:0] a);
    return a[CMD_DATA_BIT] & a[CMD_READ_BIT];
  endfunction

endpackage

`default_nettype wire

//--- hdl/shp_pin_sync.sv
// two-flop synchroniser plus edge finder for a group of pins
// assumes every input is asynchronous to sys_clk
`default_nettype none
`timescale 1ns/1ps

module shp_pin_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_sync,
  output logic      [WIDTH-1:0] pin_rise,
  output logic      [WIDTH-1:0] pin_fall
);

  // ==========================================================================
  // synchroniser stages
  logic [WIDTH-1:0] meta_reg;                                 // read only by sync_reg
  logic [WIDTH-1:0] sync_reg;                                 // safe level
  logic [WIDTH-1:0] prev_reg;                                 // delayed copy for edges

  // select idles high, so every stage resets to one and no false select edge follows reset
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg <= '1;
      sync_reg <= '1;
      prev_reg <= '1;
    end else if (clk_en) begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // edges from the second and third stages only
  assign pin_sync = sync_reg;
  assign pin_rise = sync_reg & ~prev_reg;
  assign pin_fall = ~sync_reg & prev_reg;

endmodule

`default_nettype wire

//--- hdl/shp_cmd_port.sv
// serial host command port, device side: framing, shifting, reply, write poll,
// divider staging and open-drain interrupt
// assumes host pins are asynchronous to sys_clk and the host clock is at most 5 MHz
//
// Overview of operation
// - one address byte, then optional data bytes
// - sample data bit on serial clock rise
// - reply bit valid during serial clock high
// - address byte decides data byte count
// - bytes shift most significant bit first
// - commands act on select rising edge
// - serial clock may idle low or high
// - writes taken up within poll period
// - reply pin released unless replying
// - interrupt only for unmasked status events
// - interrupt pin is open drain
// - divider entries apply on entering rx/tx
// - divider defaults suit 6.144 MHz reference
`default_nettype none
`timescale 1ns/1ps

module shp_cmd_port #(
  parameter int POLL_CYCLES = shp_pkg::POLL_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  input  wire logic        bus_select_n,
  input  wire logic        serial_clock_in,
  input  wire logic        command_data_in,
  output logic             reply_data_out,
  output logic             reply_data_oe_n,
  output logic             host_interrupt_n_out,
  output logic             host_interrupt_oe_n,
  input  wire logic [7:0]  status_event,
  output logic             rd_req,
  output logic [7:0]       rd_addr,
  input  wire logic [15:0] rd_data,
  output logic             upd_valid,
  output logic [7:0]       upd_addr,
  output logic [15:0]      upd_data,
  output logic             cmd_strobe,
  output logic [7:0]       cmd_addr,
  output logic             mode_rx,
  output logic             mode_tx,
  output logic [11:0]      div_ref,
  output logic [11:0]      div_pll,
  output logic [11:0]      div_vco,
  output logic [11:0]      div_adc
);

  // ==========================================================================
  // pin sampling
  logic [2:0] pin_s;                                          // {sel_n, sck, din}
  logic [2:0] pin_r;
  logic [2:0] pin_f;
  logic       sel_n_s;
  logic       sel_rise;
  logic       sck_rise;
  logic       sck_fall;
  logic       din_s;

  shp_pin_sync #(.WIDTH(3)) u_sync (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .clk_en    (clk_en),
    .pin_in    ({bus_select_n, serial_clock_in, command_data_in}),
    .pin_sync  (pin_s),
    .pin_rise  (pin_r),
    .pin_fall  (pin_f)
  );

  assign sel_n_s  = pin_s[2];
  assign sel_rise = pin_r[2];
  // only edges seen while selected count, so either idle level is fine
  assign sck_rise = pin_r[1] & ~sel_n_s;
  assign sck_fall = pin_f[1] & ~sel_n_s;
  assign din_s    = pin_s[0];

  // ==========================================================================
  // frame state
  shp_pkg::shp_state_t state_reg;                             // transaction phase
  logic [2:0]  bit_cnt_reg;                                   // bit within byte
  logic [1:0]  byte_cnt_reg;                                  // data bytes taken
  logic        done_reg;                                      // frame complete
  logic [7:0]  in_sh_reg;                                     // receive shifter
  logic [7:0]  addr_reg;                                      // address byte
  logic [15:0] wdata_reg;                                     // write data
  logic [7:0]  new_byte;
  logic [1:0]  addr_len;
  logic        byte_end;

  assign new_byte = {in_sh_reg[6:0], din_s};
  assign addr_len = shp_pkg::shp_cmd_len(addr_reg);
  assign byte_end = sck_rise && (bit_cnt_reg == 3'h7);

  // state and counters; surplus bytes after a complete frame are ignored
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg    <= shp_pkg::ST_IDLE;
      bit_cnt_reg  <= 3'h0;
      byte_cnt_reg <= 2'h0;
      done_reg     <= 1'b0;
    end else if (clk_en) begin
      if (sel_n_s) begin
        state_reg    <= shp_pkg::ST_IDLE;
        bit_cnt_reg  <= 3'h0;
        byte_cnt_reg <= 2'h0;
        done_reg     <= 1'b0;
      end else if (state_reg == shp_pkg::ST_IDLE) begin
        state_reg <= shp_pkg::ST_ADDR;
      end else if (sck_rise) begin
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        if (byte_end && !done_reg) begin
          case (state_reg)
            shp_pkg::ST_ADDR: begin
              // address decides what follows
              if (shp_pkg::shp_cmd_len(new_byte) == 2'h0) begin
                done_reg <= 1'b1;
              end else if (shp_pkg::shp_cmd_rd(new_byte)) begin
                state_reg <= shp_pkg::ST_RDATA;
              end else begin
                state_reg <= shp_pkg::ST_WDATA;
              end
            end
            shp_pkg::ST_WDATA: begin
              byte_cnt_reg <= byte_cnt_reg + 2'h1;
              if (byte_cnt_reg + 2'h1 == addr_len) begin
                done_reg <= 1'b1;
              end
            end
            // replies run on until deselect, zeros after the last byte
            default: begin
              state_reg <= state_reg;
            end
          endcase
        end
      end
    end
  end

  // receive shifter and captured bytes
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      in_sh_reg <= 8'h00;
      addr_reg  <= 8'h00;
      wdata_reg <= 16'h0000;
    end else if (clk_en && sck_rise && state_reg != shp_pkg::ST_IDLE) begin
      in_sh_reg <= new_byte;
      if (byte_end && !done_reg && state_reg == shp_pkg::ST_ADDR) begin
        addr_reg <= new_byte;
      end
      if (byte_end && !done_reg && state_reg == shp_pkg::ST_WDATA) begin
        wdata_reg <= {wdata_reg[7:0], new_byte};
      end
    end
  end

  // ==========================================================================
  // reply path
  logic        rd_req_reg;                                    // read request pulse
  logic        ld_reg;                                        // load reply shifter
  logic [15:0] reply_sh_reg;
  logic        reply_reg;
  logic        reply_oe_n_reg;
  logic [7:0]  status_reg;
  logic [7:0]  status_snap_reg;                               // bits sent to host
  logic        is_status;

  assign is_status = (addr_reg == shp_pkg::ADDR_STATUS);

  // request one cycle after the address byte, load the cycle after that
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_req_reg      <= 1'b0;
      ld_reg          <= 1'b0;
      reply_sh_reg    <= 16'h0000;
      status_snap_reg <= 8'h00;
      reply_reg       <= 1'b0;
    end else if (clk_en) begin
      rd_req_reg <= byte_end && state_reg == shp_pkg::ST_ADDR && !done_reg
                    && shp_pkg::shp_cmd_rd(new_byte);
      ld_reg     <= rd_req_reg;
      if (ld_reg) begin
        // one-byte replies sit in the upper half so bit 7 leaves first
        if (is_status) begin
          reply_sh_reg    <= {status_reg, 8'h00};
          status_snap_reg <= status_reg;
        end else if (addr_len == 2'h2) begin
          reply_sh_reg <= rd_data;
        end else begin
          reply_sh_reg <= {rd_data[7:0], 8'h00};
        end
      end else if (sck_fall && state_reg == shp_pkg::ST_RDATA) begin
        // change on the falling edge, so the bit is steady while clock is high
        reply_reg    <= reply_sh_reg[15];
        reply_sh_reg <= {reply_sh_reg[14:0], 1'b0};
      end
    end
  end

  // drive only while replying
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reply_oe_n_reg <= 1'b1;
    end else if (clk_en) begin
      reply_oe_n_reg <= (state_reg != shp_pkg::ST_RDATA) || sel_n_s;
    end
  end

  assign rd_req          = rd_req_reg;
  assign rd_addr         = addr_reg;
  assign reply_data_out  = reply_reg;
  assign reply_data_oe_n = reply_oe_n_reg;

  // ==========================================================================
  // end of frame actions and write poll
  logic                           wr_new;                     // write frame ended
  logic                           pend_reg;                   // write awaiting poll
  logic [7:0]                     pend_addr_reg;
  logic [15:0]                    pend_data_reg;
  logic [$clog2(POLL_CYCLES)-1:0] poll_cnt_reg;
  logic                           poll_tick;
  logic                           rel;                        // pending write taken up
  logic                           cmd_reg;

  assign wr_new    = sel_rise && done_reg && addr_len != 2'h0
                     && !shp_pkg::shp_cmd_rd(addr_reg);
  assign poll_tick = (poll_cnt_reg == ($clog2(POLL_CYCLES))'(POLL_CYCLES - 1));
  // a write to another register flushes the slot early so it is not lost
  assign rel       = pend_reg && (poll_tick || (wr_new && pend_addr_reg != addr_reg));

  // free-running poll timer
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      poll_cnt_reg <= '0;
    end else if (clk_en) begin
      poll_cnt_reg <= poll_tick ? '0 : poll_cnt_reg + 1'b1;
    end
  end

  // one pending slot; a second write to the same register replaces the first
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pend_reg      <= 1'b0;
      pend_addr_reg <= 8'h00;
      pend_data_reg <= 16'h0000;
    end else if (clk_en) begin
      if (wr_new) begin
        pend_reg      <= 1'b1;
        pend_addr_reg <= addr_reg;
        pend_data_reg <= wdata_reg;
      end else if (rel) begin
        pend_reg <= 1'b0;
      end
    end
  end

  // zero-length commands strobe at deselect
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_reg <= 1'b0;
    end else if (clk_en) begin
      cmd_reg <= sel_rise && done_reg && addr_len == 2'h0;
    end
  end

  assign cmd_strobe = cmd_reg;
  assign cmd_addr   = addr_reg;

  // ==========================================================================
  // released writes: local registers or out to the core
  logic [7:0]  mode_reg;
  logic [7:0]  mask_reg;
  logic        upd_reg;
  logic [7:0]  upd_addr_reg;
  logic [15:0] upd_data_reg;
  logic        mode_enter;

  assign mode_enter = rel && pend_addr_reg == shp_pkg::ADDR_MODE
                      && ((pend_data_reg[shp_pkg::MODE_RX_BIT] && !mode_reg[shp_pkg::MODE_RX_BIT])
                      || (pend_data_reg[shp_pkg::MODE_TX_BIT] && !mode_reg[shp_pkg::MODE_TX_BIT]));

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_reg     <= shp_pkg::MODE_RESET;
      mask_reg     <= shp_pkg::MASK_RESET;
      upd_reg      <= 1'b0;
      upd_addr_reg <= 8'h00;
      upd_data_reg <= 16'h0000;
    end else if (clk_en) begin
      upd_reg <= 1'b0;
      if (rel) begin
        if (pend_addr_reg == shp_pkg::ADDR_MODE) begin
          mode_reg <= pend_data_reg[7:0];
        end else if (pend_addr_reg == shp_pkg::ADDR_MASK) begin
          mask_reg <= pend_data_reg[7:0];
        end else if (pend_addr_reg[7:2] != shp_pkg::ADDR_DIV0[7:2]) begin
          upd_reg      <= 1'b1;
          upd_addr_reg <= pend_addr_reg;
          upd_data_reg <= pend_data_reg;
        end
      end
    end
  end

  assign upd_valid = upd_reg;
  assign upd_addr  = upd_addr_reg;
  assign upd_data  = upd_data_reg;
  assign mode_rx   = mode_reg[shp_pkg::MODE_RX_BIT];
  assign mode_tx   = mode_reg[shp_pkg::MODE_TX_BIT];

  // ==========================================================================
  // clock divider entries: staged on write, applied on entering rx or tx
  logic [11:0] div_stage_reg  [0:3];
  logic [11:0] div_active_reg [0:3];

  for (genvar i = 0; i < shp_pkg::NUM_DIV; i++) begin : g_div
    always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
        div_stage_reg[i]  <= shp_pkg::DIV_DEFAULT[i];
        div_active_reg[i] <= shp_pkg::DIV_DEFAULT[i];
      end else if (clk_en) begin
        if (rel && pend_addr_reg == {shp_pkg::ADDR_DIV0[7:2], 2'(i)}) begin
          div_stage_reg[i] <= pend_data_reg[11:0];
        end
        if (mode_enter) begin
          div_active_reg[i] <= div_stage_reg[i];
        end
      end
    end
  end

  assign div_ref = div_active_reg[0];
  assign div_pll = div_active_reg[1];
  assign div_vco = div_active_reg[2];
  assign div_adc = div_active_reg[3];

  // ==========================================================================
  // status and interrupt
  logic [7:0] status_clr;
  logic       irq_cause;
  logic       irq_reg;

  // bits the host has read clear at deselect; a new event in that cycle wins
  assign status_clr = (sel_rise && state_reg == shp_pkg::ST_RDATA && is_status)
                      ? status_snap_reg : 8'h00;
  assign irq_cause  = |(status_reg & mask_reg);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      status_reg <= shp_pkg::STATUS_RESET;
      irq_reg    <= 1'b0;
    end else if (clk_en) begin
      status_reg <= (status_reg & ~status_clr) | status_event;
      irq_reg    <= irq_cause;
    end
  end

  // only ever pull low; released otherwise
  assign host_interrupt_n_out = 1'b0;
  assign host_interrupt_oe_n  = ~irq_reg;

  // ==========================================================================
  // checks
  logic [$clog2(POLL_CYCLES)+1:0] pend_age_reg;               // cycles a write waits

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pend_age_reg <= '0;
    end else if (clk_en) begin
      pend_age_reg <= (wr_new || !pend_reg) ? '0 : pend_age_reg + 1'b1;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n || !clk_en);

  sequence s_addr_end;
    byte_end && state_reg == shp_pkg::ST_ADDR && !done_reg;
  endsequence
  sequence s_rd_load;
    rd_req_reg ##1 ld_reg;
  endsequence

  property p_rd_seq;
    s_addr_end ##0 shp_pkg::shp_cmd_rd(new_byte) |=> s_rd_load;
  endproperty
  a_rd_seq: assert property (p_rd_seq) else $error("read request not issued");

  property p_len;
    s_addr_end ##0 !new_byte[shp_pkg::CMD_DATA_BIT] |=> done_reg;
  endproperty
  a_len: assert property (p_len) else $error("zero-length frame not done");

  property p_sample;
    sck_rise && state_reg != shp_pkg::ST_IDLE |=> in_sh_reg[0] == $past(din_s);
  endproperty
  a_sample: assert property (p_sample) else $error("data bit not sampled");

  property p_reply_edge;
    $changed(reply_data_out) |-> $past(sck_fall);
  endproperty
  a_reply_edge: assert property (p_reply_edge) else $error("reply changed off edge");

  property p_msb;
    sck_fall && state_reg == shp_pkg::ST_RDATA && !ld_reg
      |=> reply_data_out == $past(reply_sh_reg[15]);
  endproperty
  a_msb: assert property (p_msb) else $error("reply bit order wrong");

  property p_act_end;
    $changed(pend_addr_reg) || $rose(cmd_strobe) |-> $past(sel_rise);
  endproperty
  a_act_end: assert property (p_act_end) else $error("command acted before deselect");

  property p_poll;
    pend_age_reg <= POLL_CYCLES;
  endproperty
  a_poll: assert property (p_poll) else $error("write waited past poll period");

  property p_hiz;
    sel_n_s |=> reply_data_oe_n;
  endproperty
  a_hiz: assert property (p_hiz) else $error("reply driven while deselected");

  property p_irq;
    !$past(irq_cause) |-> host_interrupt_oe_n;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt without unmasked event");

  property p_div;
    $changed(div_ref) |-> $past(mode_enter);
  endproperty
  a_div: assert property (p_div) else $error("divider changed outside mode entry");

  property p_fresh;
    sel_n_s |=> state_reg == shp_pkg::ST_IDLE && bit_cnt_reg == 3'h0;
  endproperty
  a_fresh: assert property (p_fresh) else $error("counters not cleared");

endmodule

`default_nettype wire

//--- verif/shp_host_model.sv
// host model: frames transfers on the serial command port
// assumes the bench clock sys_clk; pins move on its falling edge
`timescale 1ns/1ps
`default_nettype none
module shp_host_model (
  input  wire logic sys_clk,
  input  wire logic reply_data_out,
  output logic      bus_select_n,
  output logic      serial_clock_in,
  output logic      command_data_in
);
  // ==========================================================
  // idle: deselected, clock low
  initial begin
    bus_select_n = 1'b1;
    serial_clock_in = 1'b0;
    command_data_in = 1'b0;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // one frame; ib clock idle level, nb data bytes, 6-cycle half period
  task automatic xfer(input logic [7:0] a, input int nb, input logic [15:0] wd,
                      input logic ib, output logic [15:0] rd);
    logic [23:0] w;
    w = (nb == 2) ? {a, wd} : {a, wd[7:0], 8'h00};
    rd = 16'h0000;
    repeat (2) begin // stray edges while deselected
      serial_clock_in = ~serial_clock_in;
      cyc(6);
    end
    serial_clock_in = ib;
    cyc(6);
    bus_select_n = 1'b0;
    cyc(6);
    for (int i = 0; i < 8 + 8 * nb; i++) begin
      serial_clock_in = 1'b0;
      command_data_in = w[23-i];
      cyc(6);
      serial_clock_in = 1'b1;
      cyc(5);
      rd = {rd[14:0], reply_data_out};
      cyc(1);
    end
    serial_clock_in = ib;
    cyc(6);
    bus_select_n = 1'b1;
    command_data_in = ~command_data_in; // no stale level after release
    cyc(12);
  endtask
endmodule
`default_nettype wire

//--- verif/tb_shp_cmd_port.sv
// bench for the serial host command port with host model and note queue
// assumes shp_pkg, the design and the host model are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_shp_cmd_port;
  localparam int POLL = 50;
  logic        sys_clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, ib = 1'b0;
  logic        bus_select_n, serial_clock_in, command_data_in, reply_data_out;
  logic        reply_data_oe_n, host_interrupt_n_out, host_interrupt_oe_n, rd_req;
  logic        upd_valid, cmd_strobe, mode_rx, mode_tx;
  logic [7:0]  status_event = 8'h00, rd_addr, upd_addr, cmd_addr;
  logic [7:0]  tab [4] = '{8'h12, 8'h7f, 8'hb0, 8'hbf};
  logic [15:0] rd_data = 16'h0000, rd_word = 16'h0000, got, wd, upd_data;
  logic        rd_due = 1'b0, reply_line;
  logic [11:0] div_ref, div_pll, div_vco, div_adc;
  logic [47:0] notes [$];
  int          seed = 32'h1051, mismatches = 0, checks_done = 0, cycles = 0;
  always #5 sys_clk = ~sys_clk;
  shp_cmd_port #(.POLL_CYCLES(POLL)) DUT (.sys_clk, .reset_n, .clk_en, .bus_select_n,
    .serial_clock_in, .command_data_in, .reply_data_out, .reply_data_oe_n, .host_interrupt_n_out,
    .host_interrupt_oe_n, .status_event, .rd_req, .rd_addr, .rd_data, .upd_valid, .upd_addr,
    .upd_data, .cmd_strobe, .cmd_addr, .mode_rx, .mode_tx, .div_ref, .div_pll, .div_vco,
    .div_adc);
  // a released reply pin shows the inverse, so a sample taken too early cannot pass
  assign reply_line = reply_data_oe_n ? ~reply_data_out : reply_data_out;
  shp_host_model host (.sys_clk, .reply_data_out(reply_line), .bus_select_n,
    .serial_clock_in, .command_data_in);
  task automatic check(input string what, input logic [47:0] exp, input logic [47:0] seen);
    checks_done++;
    if (exp !== seen) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    if (mismatches == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // frame, flip the idle level, then the reply pin must be released
  task automatic go(input logic [7:0] a, input int nb, input logic [15:0] d);
    host.xfer(a, nb, d, ib, got);
    ib = ~ib;
    check("reply_oe_n", 48'h1, {47'h0, reply_data_oe_n});
  endtask
  // core holds its answer through the whole cycle after a request
  always @(negedge sys_clk) begin
    rd_due  <= (rd_req === 1'b1);
    rd_data <= (rd_req === 1'b1 || rd_due) ? rd_word : ~rd_word;
  end
  // watcher on the falling edge, where outputs have settled;
  // ceiling well above the ~3000 cycles the run needs
  always @(negedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      complete_run();
    end
    if (upd_valid === 1'b1 || cmd_strobe === 1'b1)
      check("result", notes.size() > 0 ? notes.pop_front() : 48'hx, {23'h0, cmd_strobe,
        cmd_strobe ? {cmd_addr, 16'h0000} : {upd_addr, upd_data}});
  end
  initial begin
    repeat (20) @(negedge sys_clk);
    reset_n = 1'b1;
    host.cyc(5);
    check("dividers", {shp_pkg::DIV_DEFAULT[0], shp_pkg::DIV_DEFAULT[1],
      shp_pkg::DIV_DEFAULT[2], shp_pkg::DIV_DEFAULT[3]}, {div_ref, div_pll, div_vco, div_adc});
    foreach (tab[i]) begin
      wd = (i < 2) ? 16'h0000 : 16'($random(seed));
      notes.push_back({23'h0, i < 2, tab[i], wd});
      go(tab[i], (i < 2) ? 0 : 2, wd);
      host.cyc(POLL + 5);
    end
    rd_word = 16'($random(seed));
    go(8'he0, 2, 16'h0000);
    check("read2", {32'h0, rd_word}, {32'h0, got});
    go(8'hd0, 1, 16'h0000);
    check("read1", {32'h0, 8'hd0, rd_word[7:0]}, {32'h0, rd_addr, got[7:0]});
    go(8'ha4, 2, 16'h0123);
    host.cyc(POLL + 5);
    check("div_held", {36'h0, shp_pkg::DIV_DEFAULT[0]}, {36'h0, div_ref});
    go(8'h81, 1, 16'h0001);
    host.cyc(POLL + 5);
    check("mode_div", {34'h1, 12'h123}, {34'h0, mode_tx, mode_rx, div_ref});
    status_event = 8'h01;
    host.cyc(1);
    status_event = 8'h00;
    host.cyc(3);
    check("masked", 48'h1, {47'h0, host_interrupt_oe_n});
    go(8'h82, 1, 16'h0001);
    host.cyc(POLL + 5);
    check("irq", 48'h0, {46'h0, host_interrupt_n_out, host_interrupt_oe_n});
    go(8'hc6, 1, 16'h0000);
    check("status", {40'h0, 8'h01}, {40'h0, got[7:0]});
    check("irq_free", 48'h1, {47'h0, host_interrupt_oe_n});
    check("notes_left", 48'h0, 48'(notes.size()));
    complete_run();
  end
endmodule
`default_nettype wire
